// File: core/sic_cfg.svh
// Summary of operation
// - line sync sense auto-detected or set manually
// - polarity 0 falling edge, 1 rising edge
// - clock generator locks leading edge; trailing clamps
// - frame sync feeds field and coast; polarity
// - slicer threshold 8-256 mV, 8 mV steps
// - noninverting composite; vertical removed before line path
// - external clamp only when source bit set
// - internal clamp: delay then width after trailing
// - clamp strobe sense auto or manual field
// - external clock select bit uses shared pin
// - clock and coast on shared pin stay independent
// - coast holds clock generator, stops line tracking
// - coast sense auto or manual, default auto
// - manual power-down obeys pin at programmed level
// - slicer output selects one of four sources
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH
`define SIC_IDX_CLK 6'h03
`define SIC_IDX_LPOL 6'h12
`define SIC_IDX_FPOL 6'h14
`define SIC_IDX_CLAMP 6'h18
`define SIC_IDX_KPOL 6'h1B
`define SIC_IDX_SOUT 6'h1D
`define SIC_IDX_PWR 6'h1E
`define SIC_IDX_THR 6'h20
`define SIC_IDX_CHAN 6'h21
`define SIC_IDX_STAT 6'h22
`define SIC_IDX_CDLY 6'h23
`define SIC_IDX_CWID 6'h24
`define SIC_EXTCLK_BIT 2
`define SIC_POL_LSB 4
`define SIC_CPOL_LSB 6
`define SIC_CSRC_BIT 4
`define SIC_PDMAN_BIT 4
`define SIC_PDPOL_BIT 2
`define SIC_POL_RESET 2'h1
`define SIC_THR_STEP_MV 8
`define SIC_THR_RESET_MV 128
`define SIC_THR_RESET 5'(`SIC_THR_RESET_MV / `SIC_THR_STEP_MV - 1)
`define SIC_CDLY_RESET 8'h10
`define SIC_CWID_RESET 8'h10
`define SIC_REGEN_WIDTH 8'h08
`define SIC_VSEP_CYCLES 12'h100
`endif

// File: core/sic_pkg.sv
package sic_pkg;
  // manual=1 forces level; manual=0 takes the detected sense
  typedef struct packed {
    logic manual;
    logic level;
  } sic_pol_t;
  typedef struct packed {
    logic line;
    logic frame;
    logic green;
    logic clamp;
  } sic_sync_t;
  typedef enum logic [1:0] {
    SIC_SRC_GREEN,
    SIC_SRC_LINE,
    SIC_SRC_REGEN,
    SIC_SRC_FILT
  } sic_src_t;
  typedef enum {
    SIC_CL_IDLE,
    SIC_CL_DELAY,
    SIC_CL_WIDTH
  } sic_clamp_t;
endpackage

// File: core/sic_top.sv
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sic_cfg.svh"
module sic_top
  import sic_pkg::*;
#(
  parameter int RUN_W = 12
) (
  input wire logic mclk_in, // 40 MHz system clock
  input wire logic reset_in, // synchronous, active high
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_we_in, // write enable
  input wire logic [7:0] wb_adr_in, // byte address
  input wire logic [3:0] wb_sel_in, // byte lanes
  input wire logic [31:0] wb_dat_in, // write data
  output logic [31:0] wb_dat_out, // read data
  output logic wb_ack_out, // acknowledge
  input wire logic line_sync_in_a, // line sync, set a
  input wire logic line_sync_in_b, // line sync, set b
  input wire logic frame_sync_in_a, // frame sync, set a
  input wire logic frame_sync_in_b, // frame sync, set b
  input wire logic green_sync_slicer_in_a, // slicer result, set a
  input wire logic green_sync_slicer_in_b, // slicer result, set b
  input wire logic clamp_strobe_in, // external clamp strobe
  input wire logic external_pixel_clock_in, // shared clock / coast pin
  input wire logic sleep_pin, // power-down pin
  output logic slicer_result_out, // selected slicer output
  output logic [4:0] slicer_threshold_out, // threshold code, (n+1)*8 mV
  output logic pll_edge_out, // leading-edge pulse to clock generator
  output logic pll_hold_out, // coast: hold frequency and phase
  output logic ext_clock_sel_out, // pixel clock taken from shared pin
  output logic field_edge_out, // frame leading-edge pulse
  output logic clamp_out, // clamp window
  output logic power_down_out // power-down request
);
  logic ext_clk_sel;
  sic_pol_t line_pol, frame_pol, coast_pol, clamp_pol;
  logic clamp_ext;
  sic_src_t out_src;
  logic pd_manual, pd_level;
  logic [4:0] threshold;
  logic chan_b, use_green;
  logic [7:0] clamp_delay, clamp_width;
  sic_sync_t raw;
  logic [3:0] det, eff_pol, act, act_d;
  logic [RUN_W-1:0] green_run;
  logic vsep, green_line;
  logic line_act, line_lead, line_trail, frame_lead;
  logic [7:0] regen_cnt;
  sic_clamp_t cl_state;
  logic [7:0] cl_cnt;
  logic regen, int_clamp, coast, wr;
  logic [5:0] idx;
  logic [7:0] next_rdata;

  assign idx = wb_adr_in[7:2];
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0];
  // registers are byte-wide in the low lane; upper lanes read zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ext_clk_sel <= 1'b0;
      line_pol <= `SIC_POL_RESET;
      frame_pol <= `SIC_POL_RESET;
      coast_pol <= `SIC_POL_RESET;
      clamp_pol <= `SIC_POL_RESET;
      clamp_ext <= 1'b0;
      out_src <= SIC_SRC_GREEN;
      pd_manual <= 1'b0;
      pd_level <= 1'b1;
      threshold <= `SIC_THR_RESET;
      chan_b <= 1'b0;
      use_green <= 1'b0;
      clamp_delay <= `SIC_CDLY_RESET;
      clamp_width <= `SIC_CWID_RESET;
    end else if (wr) begin
      if (idx == `SIC_IDX_CLK) begin
        ext_clk_sel <= wb_dat_in[`SIC_EXTCLK_BIT];
      end else if (idx == `SIC_IDX_LPOL) begin
        line_pol <= wb_dat_in[`SIC_POL_LSB+:2];
      end else if (idx == `SIC_IDX_FPOL) begin
        frame_pol <= wb_dat_in[`SIC_POL_LSB+:2];
      end else if (idx == `SIC_IDX_CLAMP) begin
        coast_pol <= wb_dat_in[`SIC_CPOL_LSB+:2];
        clamp_ext <= wb_dat_in[`SIC_CSRC_BIT];
      end else if (idx == `SIC_IDX_KPOL) begin
        clamp_pol <= wb_dat_in[`SIC_CPOL_LSB+:2];
      end else if (idx == `SIC_IDX_SOUT) begin
        out_src <= sic_src_t'(wb_dat_in[1:0]);
      end else if (idx == `SIC_IDX_PWR) begin
        pd_manual <= wb_dat_in[`SIC_PDMAN_BIT];
        pd_level <= wb_dat_in[`SIC_PDPOL_BIT];
      end else if (idx == `SIC_IDX_THR) begin
        threshold <= wb_dat_in[4:0];
      end else if (idx == `SIC_IDX_CHAN) begin
        chan_b <= wb_dat_in[0];
        use_green <= wb_dat_in[1];
      end else if (idx == `SIC_IDX_CDLY) begin
        clamp_delay <= wb_dat_in[7:0];
      end else if (idx == `SIC_IDX_CWID) begin
        clamp_width <= wb_dat_in[7:0];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (idx == `SIC_IDX_CLK) begin
      next_rdata[`SIC_EXTCLK_BIT] = ext_clk_sel;
    end else if (idx == `SIC_IDX_LPOL) begin
      next_rdata[`SIC_POL_LSB+:2] = line_pol;
    end else if (idx == `SIC_IDX_FPOL) begin
      next_rdata[`SIC_POL_LSB+:2] = frame_pol;
    end else if (idx == `SIC_IDX_CLAMP) begin
      next_rdata[`SIC_CPOL_LSB+:2] = coast_pol;
      next_rdata[`SIC_CSRC_BIT] = clamp_ext;
    end else if (idx == `SIC_IDX_KPOL) begin
      next_rdata[`SIC_CPOL_LSB+:2] = clamp_pol;
    end else if (idx == `SIC_IDX_SOUT) begin
      next_rdata[1:0] = out_src;
    end else if (idx == `SIC_IDX_PWR) begin
      next_rdata[`SIC_PDMAN_BIT] = pd_manual;
      next_rdata[`SIC_PDPOL_BIT] = pd_level;
    end else if (idx == `SIC_IDX_THR) begin
      next_rdata[4:0] = threshold;
    end else if (idx == `SIC_IDX_CHAN) begin
      next_rdata[1:0] = {use_green, chan_b};
    end else if (idx == `SIC_IDX_STAT) begin
      next_rdata = {power_down_out, coast, clamp_out, vsep, eff_pol};
    end else if (idx == `SIC_IDX_CDLY) begin
      next_rdata = clamp_delay;
    end else if (idx == `SIC_IDX_CWID) begin
      next_rdata = clamp_width;
    end
  end
  // one wait state; unmapped addresses still ack and read zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      wb_dat_out <= {24'h00_0000, next_rdata};
    end
  end
  // input set selection; the shared pin feeds coast regardless of clock use
  assign raw.line = chan_b ? line_sync_in_b : line_sync_in_a;
  assign raw.frame = chan_b ? frame_sync_in_b : frame_sync_in_a;
  assign raw.green = chan_b ? green_sync_slicer_in_b : green_sync_slicer_in_a;
  assign raw.clamp = clamp_strobe_in;
  assign ext_clock_sel_out = ext_clk_sel;
  assign slicer_threshold_out = threshold;
  // sense detection: the active level is the shorter of the two run lengths
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_det
      logic sig, sig_d;
      logic [RUN_W-1:0] run, hi_len, lo_len;
      sic_pol_t pol;
      assign sig = (gi == 0) ? raw.line : (gi == 1) ? raw.frame :
                   (gi == 2) ? external_pixel_clock_in : raw.clamp;
      assign pol = (gi == 0) ? line_pol : (gi == 1) ? frame_pol :
                   (gi == 2) ? coast_pol : clamp_pol;
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          sig_d <= 1'b0;
          run <= '0;
          hi_len <= '1;
          lo_len <= '1;
        end else begin
          sig_d <= sig;
          if (sig != sig_d) begin
            run <= '0;
            if (sig_d) begin
              hi_len <= run;
            end else begin
              lo_len <= run;
            end
          end else if (run != '1) begin
            run <= run + 1'b1;
          end
        end
      end
      assign det[gi] = hi_len < lo_len;
      assign eff_pol[gi] = pol.manual ? pol.level : det[gi];
      assign act[gi] = eff_pol[gi] ? sig : !sig;
    end
  endgenerate
  // composite separation: a green pulse held longer than SIC_VSEP_CYCLES (256 cycles) is vertical
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      green_run <= '0;
      vsep <= 1'b0;
    end else begin
      if (!raw.green) begin
        green_run <= '0;
        vsep <= 1'b0;
      end else if (green_run != RUN_W'(`SIC_VSEP_CYCLES)) begin
        green_run <= green_run + 1'b1;
      end else begin
        vsep <= 1'b1;
      end
    end
  end
  // vertical portion is masked off before the line path sees it
  assign green_line = raw.green && !vsep;
  assign line_act = use_green ? green_line : act[0];
  // no reset: the delayed copy tracks the live levels, so no false edge follows reset
  always_ff @(posedge mclk_in) begin
    act_d <= {act[3:1], line_act};
  end
  assign line_lead = line_act && !act_d[0];
  assign line_trail = !line_act && act_d[0];
  assign frame_lead = act[1] && !act_d[1];
  // frame sync interval also coasts the generator, ORed with the pin coast
  assign coast = act[2] || act[1];
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pll_edge_out <= 1'b0;
      pll_hold_out <= 1'b0;
      field_edge_out <= 1'b0;
    end else begin
      pll_edge_out <= line_lead && !coast;
      pll_hold_out <= coast;
      field_edge_out <= frame_lead;
    end
  end
  // regenerated line sync: fixed-width pulse from each leading edge
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      regen_cnt <= 8'h00;
    end else if (line_lead) begin
      regen_cnt <= `SIC_REGEN_WIDTH;
    end else if (regen_cnt != 8'h00) begin
      regen_cnt <= regen_cnt - 8'h01;
    end
  end
  assign regen = regen_cnt != 8'h00;
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      slicer_result_out <= 1'b0;
    end else begin
      case (out_src)
        SIC_SRC_GREEN: slicer_result_out <= raw.green;
        SIC_SRC_LINE: slicer_result_out <= raw.line;
        SIC_SRC_REGEN: slicer_result_out <= regen;
        default: slicer_result_out <= green_line;
      endcase
    end
  end
  // internal clamp: delay then width, counted from the trailing edge
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cl_state <= SIC_CL_IDLE;
      cl_cnt <= 8'h00;
    end else begin
      case (cl_state)
        SIC_CL_IDLE: begin
          if (line_trail) begin
            cl_state <= SIC_CL_DELAY;
            cl_cnt <= clamp_delay;
          end
        end
        SIC_CL_DELAY: begin
          if (cl_cnt == 8'h00) begin
            cl_state <= (clamp_width == 8'h00) ? SIC_CL_IDLE : SIC_CL_WIDTH;
            cl_cnt <= clamp_width - 8'h01;
          end else begin
            cl_cnt <= cl_cnt - 8'h01;
          end
        end
        default: begin
          if (cl_cnt == 8'h00) begin
            cl_state <= SIC_CL_IDLE;
          end else begin
            cl_cnt <= cl_cnt - 8'h01;
          end
        end
      endcase
    end
  end
  assign int_clamp = cl_state == SIC_CL_WIDTH;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      clamp_out <= 1'b0;
      power_down_out <= 1'b0;
    end else begin
      clamp_out <= clamp_ext ? act[3] : int_clamp;
      power_down_out <= pd_manual && (sleep_pin == pd_level);
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence s_trail;
    !line_act && act_d[0];
  endsequence
  sequence s_delay_start;
    cl_state == SIC_CL_DELAY;
  endsequence

  a_clamp_start: assert property (
    ((cl_state == SIC_CL_IDLE) and s_trail) |=> s_delay_start)
    else $error("clamp delay did not start on trailing edge");
  a_clamp_ext: assert property (
    clamp_ext |=> clamp_out == $past(act[3]))
    else $error("external clamp not followed");
  a_clamp_int: assert property (
    !clamp_ext |=> clamp_out == $past(int_clamp))
    else $error("clamp pin not ignored");
  a_edge_lead: assert property (
    pll_edge_out |-> $past(line_lead) && !$past(coast))
    else $error("edge pulse without leading edge");
  a_coast_hold: assert property (
    coast |=> pll_hold_out && !pll_edge_out)
    else $error("coast did not hold generator");
  a_pd_pin: assert property (
    !pd_manual |=> !power_down_out)
    else $error("power down without manual mode");
  a_pol_manual: assert property (
    line_pol.manual |-> eff_pol[0] == line_pol.level)
    else $error("manual line polarity ignored");
  a_slicer_sel: assert property (
    out_src == SIC_SRC_LINE ##1 out_src == SIC_SRC_LINE |->
    slicer_result_out == $past(raw.line))
    else $error("slicer output source wrong");
  a_vsep_mask: assert property (
    (vsep && out_src == SIC_SRC_FILT) |=> !slicer_result_out)
    else $error("vertical part reached line path");
  a_frame_field: assert property (
    frame_lead |=> field_edge_out)
    else $error("field edge missing");
  a_ack_pulse: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// File: tb/sic_src.sv
`timescale 1ns/10ps
`default_nettype none
module sic_src (
  input wire logic mclk_in, // bench clock
  output logic line_a_out, // line sync, set a
  output logic line_b_out, // line sync, set b
  output logic frame_a_out, // frame sync, set a
  output logic frame_b_out, // frame sync, set b
  output logic green_a_out, // slicer result, set a
  output logic green_b_out, // slicer result, set b
  output logic strobe_out, // clamp strobe
  output logic coast_out, // shared clock / coast pin
  output logic sleep_out // power-down pin
);
  // bits: 0 line, 1 frame, 2 green, 3 strobe, 4 coast, 5 sleep, 6 set b in use
  logic [6:0] lvl;
  logic tog;
  initial begin
    lvl = 7'h00; // shared pin grounded, sleep pin tied low when idle
    tog = 1'b0;
  end
  always @(posedge mclk_in) begin
    tog <= ~tog;
  end
  // the idle set keeps toggling, so a wrong set selection cannot hide
  assign line_a_out = lvl[6] ? tog : lvl[0];
  assign line_b_out = lvl[6] ? lvl[0] : tog;
  assign frame_a_out = lvl[6] ? tog : lvl[1];
  assign frame_b_out = lvl[6] ? lvl[1] : tog;
  assign green_a_out = lvl[6] ? tog : lvl[2];
  assign green_b_out = lvl[6] ? lvl[2] : tog;
  assign strobe_out = lvl[3];
  assign coast_out = lvl[4];
  assign sleep_out = lvl[5];
  // strobe is raised only between line pulses, some 60 cycles after a line trailing edge
  task automatic drive(input int kind, input logic v, input int cycles);
    @(posedge mclk_in);
    lvl[kind] <= v;
    repeat (cycles - 1) @(posedge mclk_in);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk_in, reset_in, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic ln_a, ln_b, fr_a, fr_b, gr_a, gr_b, strobe, coast, sleep;
  logic slicer, pll_edge, hold, extsel, field, clamp, pdown;
  logic [4:0] thr;
  int err_total, total_checks, edge_cnt, field_cnt, clamp_cnt, e1, e2, c;

  sic_top u_sic_top (.mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .line_sync_in_a(ln_a), .line_sync_in_b(ln_b),
    .frame_sync_in_a(fr_a), .frame_sync_in_b(fr_b), .green_sync_slicer_in_a(gr_a),
    .green_sync_slicer_in_b(gr_b), .clamp_strobe_in(strobe),
    .external_pixel_clock_in(coast), .sleep_pin(sleep), .slicer_result_out(slicer),
    .slicer_threshold_out(thr), .pll_edge_out(pll_edge), .pll_hold_out(hold),
    .ext_clock_sel_out(extsel), .field_edge_out(field), .clamp_out(clamp),
    .power_down_out(pdown));
  sic_src u_sic_src (.mclk_in(mclk_in), .line_a_out(ln_a), .line_b_out(ln_b),
    .frame_a_out(fr_a), .frame_b_out(fr_b), .green_a_out(gr_a), .green_b_out(gr_b),
    .strobe_out(strobe), .coast_out(coast), .sleep_out(sleep));

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // counters are only ever read as differences, so no clear can race them
  always @(posedge mclk_in) begin
    edge_cnt <= edge_cnt + int'(pll_edge);
    field_cnt <= field_cnt + int'(field);
    clamp_cnt <= clamp_cnt + int'(clamp);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check("bus ack", ack, 32'h1);
  endtask
  task automatic line_pulse(input logic act);
    int b0, c0;
    u_sic_src.drive(0, ~act, 60);
    b0 = edge_cnt;
    c0 = clamp_cnt;
    u_sic_src.drive(0, act, 20);
    e1 = edge_cnt - b0;
    u_sic_src.drive(0, ~act, 60);
    e2 = edge_cnt - b0;
    c = clamp_cnt - c0;
  endtask

  task automatic test_reset;
    check("threshold out", thr, 32'h0F);
    check("hold out", hold, 32'h0);
    wb(0, 6'h20, 0);
    check("threshold reg", q, 32'h0F);
    wb(0, 6'h18, 0);
    check("clamp reg", q, 32'h40);
    wb(0, 6'h1E, 0);
    check("power reg", q, 32'h04);
    wb(1, 6'h3F, 8'hFF);
    wb(0, 6'h3F, 0);
    check("unmapped", q, 32'h0);
    wb(1, 6'h20, 8'h1F);
    wb(0, 6'h20, 0);
    check("threshold 256", thr, 32'h1F);
    sel <= 4'h0;
    wb(1, 6'h20, 8'h05);
    sel <= 4'hF;
    check("masked write", thr, 32'h1F);
    wb(1, 6'h14, 8'h30);
    wb(1, 6'h18, 8'hC0);
    $display("test reset done");
  endtask
  task automatic test_line;
    for (int i = 0; i < 2; i++) begin
      wb(1, 6'h12, i ? 8'h30 : 8'h20);
      line_pulse(i[0]);
      check("leading pulses", e1, 32'h1);
      check("trailing pulses", e2, 32'h1);
      check("clamp cycles", c, i ? 32'h5 : 32'h10);
      wb(1, 6'h24, 8'h05);
    end
    $display("test line done");
  endtask
  task automatic test_clamp;
    int b;
    wb(1, 6'h1B, 8'hC0);
    wb(1, 6'h18, 8'hD0);
    for (int i = 0; i < 2; i++) begin
      line_pulse(1'b1);
      check("internal clamp", c, i ? 32'h5 : 32'h0);
      b = clamp_cnt;
      u_sic_src.drive(3, 1'b1, 10);
      u_sic_src.drive(3, 1'b0, 10);
      check("strobe clamp", clamp_cnt - b, i ? 32'h0 : 32'hA);
      wb(1, 6'h18, 8'hC0);
    end
    $display("test clamp done");
  endtask
  task automatic test_coast;
    u_sic_src.drive(4, 1'b1, 5);
    check("coast hold", hold, 32'h1);
    line_pulse(1'b1);
    check("coast edges", e2, 32'h0);
    u_sic_src.drive(4, 1'b0, 5);
    wb(1, 6'h03, 8'h04);
    check("ext clock", extsel, 32'h1);
    line_pulse(1'b1);
    check("ext edges", e2, 32'h1);
    check("ext hold", hold, 32'h0);
    wb(1, 6'h03, 8'h00);
    $display("test coast done");
  endtask
  task automatic test_frame;
    int b;
    b = field_cnt;
    u_sic_src.drive(1, 1'b1, 20);
    check("frame hold", hold, 32'h1);
    u_sic_src.drive(1, 1'b0, 20);
    check("field pulses", field_cnt - b, 32'h1);
    $display("test frame done");
  endtask
  task automatic test_power;
    logic [7:0] pw [4] = '{8'h14, 8'h14, 8'h10, 8'h04};
    logic pin [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wb(1, 6'h1E, pw[i]);
      u_sic_src.drive(5, pin[i], 4);
      check("power down", pdown, exp[i]);
    end
    u_sic_src.drive(5, 1'b0, 4);
    $display("test power done");
  endtask
  task automatic test_route;
    int b;
    for (int i = 0; i < 4; i++) begin
      wb(1, 6'h1D, i[7:0]);
      u_sic_src.drive((i == 1 || i == 2) ? 0 : 2, 1'b1, 4);
      check("slicer high", slicer, 32'h1);
      u_sic_src.drive((i == 1 || i == 2) ? 0 : 2, 1'b0, 12);
      check("slicer low", slicer, 32'h0);
    end
    u_sic_src.drive(2, 1'b1, 300);
    check("filtered vertical", slicer, 32'h0);
    wb(0, 6'h22, 0);
    check("status", q, 32'h1F);
    u_sic_src.drive(2, 1'b0, 4);
    b = edge_cnt;
    wb(1, 6'h21, 8'h02);
    u_sic_src.drive(2, 1'b1, 20);
    u_sic_src.drive(2, 1'b0, 20);
    check("green line edges", edge_cnt - b, 32'h1);
    wb(1, 6'h21, 8'h01);
    u_sic_src.drive(6, 1'b1, 5);
    line_pulse(1'b1);
    check("set b edges", e2, 32'h1);
    u_sic_src.drive(6, 1'b0, 5);
    wb(1, 6'h21, 8'h00);
    $display("test route done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    err_total = 0;
    total_checks = 0;
    edge_cnt = 0;
    field_cnt = 0;
    clamp_cnt = 0;
    reset_in = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    test_reset;
    test_line;
    test_clamp;
    test_coast;
    test_frame;
    test_power;
    test_route;
    report_and_stop;
  end
  // the whole sequence needs about 1600 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
